// [inc/cssc_map.vh]
// Selector codes, field positions and reset values for the state registers
`ifndef CSSC_MAP_VH
`define CSSC_MAP_VH

// ------------------------------------------------------------
// Register selector codes
// ------------------------------------------------------------
`define CSSC_SEL_EXEC 2'h0
`define CSSC_SEL_VTOR 2'h1
`define CSSC_SEL_SCR 2'h2

// ------------------------------------------------------------
// Execution state fields
// ------------------------------------------------------------
`define CSSC_EX_T_BIT 24
`define CSSC_EX_HI_MSB 26
`define CSSC_EX_HI_LSB 25
`define CSSC_EX_IDX_MSB 15
`define CSSC_EX_IDX_LSB 12
`define CSSC_EX_LO_MSB 11
`define CSSC_EX_LO_LSB 10
`define CSSC_EX_MASK 32'h0700fc00
`define CSSC_EX_RESET 32'h00000000

// ------------------------------------------------------------
// Vector table offset fields
// ------------------------------------------------------------
`define CSSC_VT_MSB 29
`define CSSC_VT_LSB 7
`define CSSC_VT_REGION_BIT 29
`define CSSC_VT_RESET 23'h000000

// ------------------------------------------------------------
// Low power control fields
// ------------------------------------------------------------
`define CSSC_SCR_ANYPEND_BIT 4
`define CSSC_SCR_DEEP_BIT 2
`define CSSC_SCR_EXITSLP_BIT 1
`define CSSC_SCR_RESET 3'h0

`endif

// [core/cssc_core.v]
// Core execution state, vector table offset and low power control registers
`timescale 1ns/10ps
`include "cssc_map.vh"

// Function
// - Move-instruction reads of execution state always return zero.
// - Move-instruction writes to execution state change nothing.
// - Interrupted multi transfer records next register index in bits 15..12.
// - After servicing, the transfer resumes from the recorded index.
// - While holding multi transfer state, bits 26..25 and 11..10 are zero.
// - Conditional block covers at most four instructions; condition bit 0 follows the shifting mask.
// - State bit cleared only by reset, exchange branch, restore or vector.
// - Executing with instruction set bit at zero raises a fault.
// - Vector offset field holds bits 29..7 of table base offset.
// - Bit 29 selects code region (0) or SRAM region (1).
// - Vector offset bits 6..0 always zero, not stored.
// - Wake-on-any-pending at one lets disabled interrupts wake the core too.
// - Pending event wakes wait-for-event, else latched for the next one.
// - Send-event instruction wakes wait-for-event sleep only; external event input wakes either sleep.
// - Deep low power select picks sleep (0) or deep sleep (1).
// - Sleep after handler return set puts the core to sleep on return.
module cssc_core
(
    input wire clk,
    input wire rst_n,
    input wire sysreg_wr,
    input wire sysreg_rd,
    input wire [1:0] sysreg_sel,
    input wire [31:0] sysreg_wdata,
    output reg [31:0] sysreg_rdata_ff,
    output reg sysreg_rvalid_ff,
    input wire mtx_interrupt,
    input wire [3:0] mtx_next_idx,
    input wire mtx_resume,
    output reg mtx_resume_go_ff,
    output reg [3:0] mtx_resume_idx_ff,
    input wire cond_block_open,
    input wire [7:0] cond_block_val,
    input wire instr_retire,
    output reg [3:0] cond_block_cond_ff,
    output reg cond_block_active_ff,
    input wire bx_exec,
    input wire bx_target_bit0,
    input wire exc_return_restore,
    input wire [31:0] stacked_status,
    input wire vector_load,
    input wire vector_bit0,
    input wire fetch_exec,
    output reg inv_state_fault_ff,
    output reg [31:0] exec_state_ff,
    output reg [31:0] vector_table_base_ff,
    output reg vector_region_ff,
    input wire wait_for_event_instr,
    input wire send_event_instr,
    input wire ext_event,
    input wire irq_pend_enabled,
    input wire irq_pend_disabled,
    input wire exc_return_to_thread,
    output reg core_sleep_ff,
    output reg core_deep_sleep_ff,
    output reg wake_pulse_ff
);

localparam ST_RUN = 2'h0;
localparam ST_WFE = 2'h1;
localparam ST_EXIT_SLEEP = 2'h2;

// ------------------------------------------------------------
// External event synchroniser
// ------------------------------------------------------------
reg ext_s1_ff;
reg ext_s2_ff;
reg ext_s3_ff;
reg ext_lvl_ff;
wire ext_rise;

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        ext_s1_ff <= 1'b0;
        ext_s2_ff <= 1'b0;
        ext_s3_ff <= 1'b0;
        ext_lvl_ff <= 1'b0;
    end
    else
    begin
        ext_s1_ff <= ext_event;
        ext_s2_ff <= ext_s1_ff;
        ext_s3_ff <= ext_s2_ff;
        if (ext_s2_ff == ext_s3_ff)
            ext_lvl_ff <= ext_s3_ff;
    end
end

// A rise counts only once two late stages agree
assign ext_rise = ext_s2_ff & ext_s3_ff & ~ext_lvl_ff;

// ------------------------------------------------------------
// Execution state
// ------------------------------------------------------------
reg [31:0] nxt_exec_state;
reg [7:0] cur_cond;
reg [7:0] nxt_cond;
reg cur_t;

always @*
begin
    nxt_exec_state = exec_state_ff;
    cur_cond = {exec_state_ff[`CSSC_EX_IDX_MSB:`CSSC_EX_LO_LSB],
                exec_state_ff[`CSSC_EX_HI_MSB:`CSSC_EX_HI_LSB]};
    cur_t = exec_state_ff[`CSSC_EX_T_BIT];
    nxt_cond = cur_cond;
    if (exc_return_restore)
    begin
        // Unstacked value restores every field, T included
        nxt_exec_state = stacked_status & `CSSC_EX_MASK;
    end
    else if (mtx_interrupt)
    begin
        nxt_exec_state = 32'h00000000;
        nxt_exec_state[`CSSC_EX_T_BIT] = cur_t;
        nxt_exec_state[`CSSC_EX_IDX_MSB:`CSSC_EX_IDX_LSB] = mtx_next_idx;
    end
    else
    begin
        if (mtx_resume)
            nxt_cond = 8'h00;
        else if (cond_block_open)
            nxt_cond = cond_block_val;
        else if (instr_retire && cur_cond[3:0] != 4'h0)
        begin
            // Mask shifts once per instruction, empty after at most four
            if (cur_cond[2:0] == 3'h0)
                nxt_cond = 8'h00;
            else
                nxt_cond = {cur_cond[7:5], cur_cond[3:0], 1'b0};
        end
        nxt_exec_state = 32'h00000000;
        nxt_exec_state[`CSSC_EX_HI_MSB:`CSSC_EX_HI_LSB] = nxt_cond[1:0];
        nxt_exec_state[`CSSC_EX_IDX_MSB:`CSSC_EX_LO_LSB] = nxt_cond[7:2];
        nxt_exec_state[`CSSC_EX_T_BIT] = cur_t;
        if (vector_load)
            nxt_exec_state[`CSSC_EX_T_BIT] = vector_bit0;
        else if (bx_exec)
            nxt_exec_state[`CSSC_EX_T_BIT] = bx_target_bit0;
    end
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        exec_state_ff <= `CSSC_EX_RESET;
        mtx_resume_go_ff <= 1'b0;
        mtx_resume_idx_ff <= 4'h0;
        cond_block_cond_ff <= 4'h0;
        cond_block_active_ff <= 1'b0;
        inv_state_fault_ff <= 1'b0;
    end
    else
    begin
        exec_state_ff <= nxt_exec_state;
        mtx_resume_go_ff <= mtx_resume;
        if (mtx_resume)
            mtx_resume_idx_ff <=
                exec_state_ff[`CSSC_EX_IDX_MSB:`CSSC_EX_IDX_LSB];
        cond_block_cond_ff <= nxt_cond[7:4];
        cond_block_active_ff <= (nxt_cond[3:0] != 4'h0);
        inv_state_fault_ff <= fetch_exec & ~cur_t;
    end
end

// ------------------------------------------------------------
// Vector table offset and low power control
// ------------------------------------------------------------
reg [22:0] vt_off_ff;
reg [2:0] scr_ff;
wire wake_any;
wire wake_anypend;
wire wake_deep;
wire wake_exitslp;

assign wake_anypend = scr_ff[2];
assign wake_deep = scr_ff[1];
assign wake_exitslp = scr_ff[0];

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        vt_off_ff <= `CSSC_VT_RESET;
        scr_ff <= `CSSC_SCR_RESET;
        vector_table_base_ff <= 32'h00000000;
        vector_region_ff <= 1'b0;
    end
    else
    begin
        if (sysreg_wr && sysreg_sel == `CSSC_SEL_VTOR)
            vt_off_ff <= sysreg_wdata[`CSSC_VT_MSB:`CSSC_VT_LSB];
        if (sysreg_wr && sysreg_sel == `CSSC_SEL_SCR)
            scr_ff <= {sysreg_wdata[`CSSC_SCR_ANYPEND_BIT],
                       sysreg_wdata[`CSSC_SCR_DEEP_BIT],
                       sysreg_wdata[`CSSC_SCR_EXITSLP_BIT]};
        vector_table_base_ff <= {2'h0, vt_off_ff, 7'h00};
        vector_region_ff <= vt_off_ff[22];
    end
end

// ------------------------------------------------------------
// Register read port
// ------------------------------------------------------------
reg [31:0] nxt_rdata;

always @*
begin
    nxt_rdata = 32'h00000000;
    case (sysreg_sel)
        `CSSC_SEL_EXEC: nxt_rdata = 32'h00000000;
        `CSSC_SEL_VTOR: nxt_rdata = {2'h0, vt_off_ff, 7'h00};
        `CSSC_SEL_SCR:
        begin
            nxt_rdata[`CSSC_SCR_ANYPEND_BIT] = wake_anypend;
            nxt_rdata[`CSSC_SCR_DEEP_BIT] = wake_deep;
            nxt_rdata[`CSSC_SCR_EXITSLP_BIT] = wake_exitslp;
        end
        default: nxt_rdata = 32'h00000000;
    endcase
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        sysreg_rdata_ff <= 32'h00000000;
        sysreg_rvalid_ff <= 1'b0;
    end
    else
    begin
        sysreg_rvalid_ff <= sysreg_rd;
        // Idle data held at zero so stale values never leak
        sysreg_rdata_ff <= sysreg_rd ? nxt_rdata : 32'h00000000;
    end
end

// ------------------------------------------------------------
// Sleep and wake sequencing
// ------------------------------------------------------------
reg [1:0] slp_state_ff;
reg [1:0] nxt_slp_state;
reg evt_latch_ff;
reg nxt_evt_latch;
reg nxt_wake;
wire pend_wake;

// Disabled interrupts wake only when any-pending wake is set
assign pend_wake = irq_pend_enabled |
                   (irq_pend_disabled & wake_anypend);
assign wake_any = pend_wake | send_event_instr | ext_rise;

always @*
begin
    nxt_slp_state = slp_state_ff;
    nxt_evt_latch = evt_latch_ff;
    nxt_wake = 1'b0;
    case (slp_state_ff)
        ST_RUN:
        begin
            if (wait_for_event_instr)
            begin
                // Latch or same-cycle event consumed; latch stays set only when both occur
                if (evt_latch_ff || wake_any)
                    nxt_evt_latch = evt_latch_ff & wake_any;
                else
                    nxt_slp_state = ST_WFE;
            end
            else if (exc_return_to_thread && wake_exitslp)
            begin
                nxt_slp_state = ST_EXIT_SLEEP;
                if (wake_any)
                    nxt_evt_latch = 1'b1;
            end
            else if (wake_any)
                nxt_evt_latch = 1'b1;
        end
        ST_WFE:
        begin
            if (wake_any)
            begin
                nxt_slp_state = ST_RUN;
                nxt_wake = 1'b1;
            end
        end
        ST_EXIT_SLEEP:
        begin
            if (pend_wake || ext_rise)
            begin
                nxt_slp_state = ST_RUN;
                nxt_wake = 1'b1;
            end
            else if (send_event_instr)
                nxt_evt_latch = 1'b1;
        end
        default: nxt_slp_state = ST_RUN;
    endcase
end

always @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        slp_state_ff <= ST_RUN;
        evt_latch_ff <= 1'b0;
        wake_pulse_ff <= 1'b0;
        core_sleep_ff <= 1'b0;
        core_deep_sleep_ff <= 1'b0;
    end
    else
    begin
        slp_state_ff <= nxt_slp_state;
        evt_latch_ff <= nxt_evt_latch;
        wake_pulse_ff <= nxt_wake;
        core_sleep_ff <= (nxt_slp_state != ST_RUN) & ~wake_deep;
        core_deep_sleep_ff <= (nxt_slp_state != ST_RUN) & wake_deep;
    end
end

endmodule

// [tb/cssc_core_monitor.sv]
// Assertion checker for the core state and sleep control registers
`timescale 1ns/10ps
module cssc_core_monitor
(
    input wire clk,
    input wire rst_n,
    input wire sysreg_wr,
    input wire [31:0] sysreg_wdata,
    input wire sysreg_rd,
    input wire [1:0] sysreg_sel,
    input wire [31:0] sysreg_rdata_ff,
    input wire mtx_interrupt,
    input wire [3:0] mtx_next_idx,
    input wire mtx_resume,
    input wire mtx_resume_go_ff,
    input wire [3:0] mtx_resume_idx_ff,
    input wire exc_return_restore,
    input wire cond_block_open,
    input wire [7:0] cond_block_val,
    input wire [3:0] cond_block_cond_ff,
    input wire fetch_exec,
    input wire inv_state_fault_ff,
    input wire [31:0] exec_state_ff,
    input wire [31:0] vector_table_base_ff,
    input wire vector_region_ff,
    input wire core_sleep_ff,
    input wire core_deep_sleep_ff,
    input wire wake_pulse_ff,
    input wire irq_pend_enabled
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_exec_read_zero: assert property (
        sysreg_rd && (sysreg_sel == 2'h0 || sysreg_sel == 2'h3)
        |=> sysreg_rdata_ff == 32'h0) else $error("exec read not zero");
    a_mtx_idx_capture: assert property (
        mtx_interrupt && !exc_return_restore |=>
        exec_state_ff[15:12] == $past(mtx_next_idx) &&
        exec_state_ff[26:25] == 2'h0 && exec_state_ff[11:10] == 2'h0)
        else $error("index capture wrong");
    a_resume_idx: assert property (
        mtx_resume && !mtx_interrupt && !exc_return_restore |=>
        mtx_resume_go_ff && mtx_resume_idx_ff == $past(exec_state_ff[15:12]))
        else $error("resume index wrong");
    a_cond_open_load: assert property (
        cond_block_open && !exc_return_restore && !mtx_interrupt &&
        !mtx_resume |=> cond_block_cond_ff == $past(cond_block_val[7:4]))
        else $error("cond load wrong");
    a_fault_t_zero: assert property (
        inv_state_fault_ff ==
        ($past(fetch_exec) && !$past(exec_state_ff[24])))
        else $error("fault mismatch");
    a_vt_region: assert property (
        sysreg_wr && sysreg_sel == 2'h1 |=> ##1
        vector_region_ff == $past(sysreg_wdata[29], 2) &&
        vector_table_base_ff[29:7] == $past(sysreg_wdata[29:7], 2))
        else $error("vector offset mismatch");
    a_vt_low_zero: assert property (
        vector_table_base_ff[6:0] == 7'h0 &&
        vector_table_base_ff[31:30] == 2'h0)
        else $error("offset low bits set");
    a_wake_pending: assert property (
        (core_sleep_ff || core_deep_sleep_ff) && irq_pend_enabled |=>
        wake_pulse_ff && !core_sleep_ff && !core_deep_sleep_ff)
        else $error("no wake on pending");
endmodule
bind cssc_core cssc_core_monitor u_mon (.*);

// [tb/core_state_and_sleep_control_tb_top.sv]
// Self-checking bench for the core state and sleep control registers
`timescale 1ns/10ps
module core_state_and_sleep_control_tb_top;
    logic clk = 1'h0, rst_n = 1'h0, sysreg_wr = 1'h0, sysreg_rd = 1'h0;
    logic mtx_interrupt = 1'h0, mtx_resume = 1'h0, cond_block_open = 1'h0;
    logic instr_retire = 1'h0, bx_exec = 1'h0, bx_target_bit0 = 1'h0;
    logic exc_return_restore = 1'h0, vector_load = 1'h0, vector_bit0 = 1'h0;
    logic fetch_exec = 1'h0, wait_for_event_instr = 1'h0, ext_event = 1'h0;
    logic send_event_instr = 1'h0, irq_pend_enabled = 1'h0;
    logic irq_pend_disabled = 1'h0, exc_return_to_thread = 1'h0;
    logic [1:0] sysreg_sel = 2'h0;
    logic [3:0] mtx_next_idx = 4'h0, k;
    logic [7:0] cond_block_val = 8'h0;
    logic [31:0] sysreg_wdata = 32'h0, stacked_status = 32'h0, w;
    wire [31:0] sysreg_rdata_ff, exec_state_ff, vector_table_base_ff;
    wire [3:0] mtx_resume_idx_ff, cond_block_cond_ff;
    wire sysreg_rvalid_ff, mtx_resume_go_ff, cond_block_active_ff;
    wire inv_state_fault_ff, vector_region_ff, core_sleep_ff;
    wire core_deep_sleep_ff, wake_pulse_ff;
    int errors = 0, comparisons = 0, cyc = 0;

    cssc_core u_dut (.*);

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------
    // Drive and compare helpers
    // ------------------------------------------------------------
    task tick;
        @(posedge clk);
        #2;
    endtask
    task automatic pls(ref logic s);
        s = 1'h1;
        tick;
        s = 1'h0;
    endtask
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [1:0] s, input logic [31:0] d);
        sysreg_sel = s;
        sysreg_wdata = d;
        pls(sysreg_wr);
    endtask
    task rd(input logic [1:0] s, input logic [31:0] e);
        sysreg_sel = s;
        pls(sysreg_rd);
        cmp("rvalid", 32'h1, sysreg_rvalid_ff);
        cmp("rdata", e, sysreg_rdata_ff);
    endtask
    // Flush the event latch first so the second wait really sleeps
    task nap(input logic deep);
        pls(send_event_instr);
        pls(wait_for_event_instr);
        cmp("latch", 32'h0, core_sleep_ff | core_deep_sleep_ff);
        tick;
        pls(wait_for_event_instr);
        cmp("sleep", !deep, core_sleep_ff);
        cmp("deep", deep, core_deep_sleep_ff);
    endtask
    task woke;
        cmp("wake", 32'h4, {wake_pulse_ff, core_sleep_ff, core_deep_sleep_ff});
    endtask
    task test_done;
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            errors++;
            test_done;
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h31419ff1));
        repeat (2) @(posedge clk);
        #2;
        rst_n = 1'h1;
        cmp("exec", 32'h0, exec_state_ff);
        for (int i = 0; i < 4; i++)
            rd(i[1:0], 32'h0);
        for (int i = 0; i < 10; i++)
        begin
            w = $urandom;
            if (i == 0)
                w = 32'h20000080;
            if (i == 1)
                w = 32'hffffffff;
            wr(2'h1, w);
            rd(2'h1, w & 32'h3fffff80);
            cmp("base", w & 32'h3fffff80, vector_table_base_ff);
            cmp("region", w[29], vector_region_ff);
            w = $urandom;
            wr(2'h2, w);
            rd(2'h2, w & 32'h16);
            wr(2'h3, w);
            rd(2'h3, 32'h0);
        end
        pls(fetch_exec);
        cmp("fault", 32'h1, inv_state_fault_ff);
        stacked_status = 32'hffffffff;
        pls(exc_return_restore);
        cmp("exec", 32'h0700fc00, exec_state_ff);
        pls(fetch_exec);
        cmp("fault", 32'h0, inv_state_fault_ff);
        pls(vector_load);
        pls(fetch_exec);
        cmp("fault", 32'h1, inv_state_fault_ff);
        bx_target_bit0 = 1'h1;
        pls(bx_exec);
        pls(fetch_exec);
        cmp("fault", 32'h0, inv_state_fault_ff);
        for (int i = 0; i < 4; i++)
        begin
            k = (i == 0) ? 4'hf : $urandom;
            mtx_next_idx = k;
            pls(mtx_interrupt);
            w = {7'h0, 1'h1, 8'h0, k, 12'h0};
            cmp("exec", w, exec_state_ff);
            wr(2'h0, $urandom);
            rd(2'h0, 32'h0);
            cmp("exec", w, exec_state_ff);
            pls(mtx_resume);
            cmp("go", 32'h1, mtx_resume_go_ff);
            cmp("idx", k, mtx_resume_idx_ff);
        end
        for (int i = 0; i < 4; i++)
        begin
            k = $urandom;
            cond_block_val = {k, 4'h1};
            pls(cond_block_open);
            cmp("cond", k, cond_block_cond_ff);
            instr_retire = 1'h1;
            repeat (3)
            begin
                tick;
                cmp("active", 32'h1, cond_block_active_ff);
            end
            tick;
            instr_retire = 1'h0;
            cmp("active", 32'h0, cond_block_active_ff);
        end
        wr(2'h2, 32'h0);
        nap(1'h0);
        pls(irq_pend_disabled);
        cmp("sleep", 32'h1, core_sleep_ff);
        pls(irq_pend_enabled);
        woke;
        wr(2'h2, 32'h14);
        nap(1'h1);
        pls(irq_pend_disabled);
        woke;
        nap(1'h1);
        pls(send_event_instr);
        woke;
        nap(1'h1);
        ext_event = 1'h1;
        for (int i = 0; i < 8 && wake_pulse_ff !== 1'h1; i++)
            tick;
        woke;
        ext_event = 1'h0;
        wr(2'h2, 32'h2);
        pls(exc_return_to_thread);
        cmp("sleep", 32'h1, core_sleep_ff);
        pls(irq_pend_enabled);
        woke;
        wr(2'h2, 32'h0);
        pls(exc_return_to_thread);
        cmp("sleep", 32'h0, core_sleep_ff);
        rst_n = 1'h0;
        tick;
        tick;
        rst_n = 1'h1;
        cmp("exec", 32'h0, exec_state_ff);
        rd(2'h1, 32'h0);
        pls(fetch_exec);
        cmp("fault", 32'h1, inv_state_fault_ff);
        test_done;
    end
endmodule
